// [design/ssd_pkg.sv]
package ssd_pkg;

  // chain length limit; the device itself never needs to know its position
  localparam int unsigned CHAIN_MAX = 32'h1f;

  // response byte bit positions
  localparam int unsigned RSP_OUT_ON   = 32'h0;
  localparam int unsigned RSP_ACTUATED = 32'h1;
  localparam int unsigned RSP_INPUTS   = 32'h4;
  localparam int unsigned RSP_MARGIN   = 32'h5;
  localparam int unsigned RSP_WARNING  = 32'h6;
  localparam int unsigned RSP_ERROR    = 32'h7;

  // request byte bit positions
  localparam int unsigned REQ_RESET    = 32'h7;

  // fault byte bit positions
  localparam int unsigned FLT_OUT_A    = 32'h0;
  localparam int unsigned FLT_OUT_B    = 32'h1;
  localparam int unsigned FLT_CROSS    = 32'h2;
  localparam int unsigned FLT_TEMP     = 32'h3;
  localparam int unsigned FLT_ACTUATOR = 32'h4;
  localparam int unsigned FLT_INTERNAL = 32'h5;
  localparam int unsigned FLT_COMM     = 32'h6;

  // values after reset
  localparam logic [7:0] RSP_RESET_VAL = 8'h00;
  localparam logic [7:0] FLT_RESET_VAL = 8'h00;

  // warning-to-shutdown delay, in minutes, and the cycle count derived from it
  localparam longint unsigned WARN_DELAY_MIN = 64'h1e;
  localparam longint unsigned SEC_PER_MIN    = 64'h3c;
  localparam longint unsigned CLK_HZ         = 64'h773_5940;
  localparam int unsigned     WARN_CNT_W     = 32'h26;
  localparam logic [WARN_CNT_W-1:0] WARN_DELAY_CYC =
    WARN_CNT_W'(WARN_DELAY_MIN * SEC_PER_MIN * CLK_HZ);

  // pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 32'h3;

endpackage

// [design/ssd_warn_if.sv]
`timescale 1ns/10ps
`default_nettype none

// link between the status logic and the warning delay timer
interface ssd_warn_if;
  logic run;     // warning cause present this cycle
  logic expired; // warning has lasted the full delay

  modport ctl (output run, input expired);
  modport tmr (input run, output expired);
endinterface

`default_nettype wire

// [design/ssd_sync3.sv]
`timescale 1ns/10ps
`default_nettype none

module ssd_sync3 (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  // pin side
  input  wire logic pin_i,
  // clean level
  output logic      level_o
);
  import ssd_pkg::*;

  // synchroniser stages and the settled level
  typedef struct packed {
    logic [SYNC_STAGES-1:0] stage;
    logic                   level;
  } ssd_sync_t;

  ssd_sync_t sy_r;
  ssd_sync_t sy_nxt;

  // first stage feeds only the second; level moves once stages two and three agree
  always_comb begin
    sy_nxt       = sy_r;
    sy_nxt.stage = {sy_r.stage[SYNC_STAGES-2:0], pin_i};
    if (sy_r.stage[1] == sy_r.stage[2]) begin
      sy_nxt.level = sy_r.stage[2];
    end
  end

  // single state register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sy_r <= '0;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign level_o = sy_r.level;

endmodule // ssd_sync3

`default_nettype wire

// [design/ssd_warn_timer.sv]
`timescale 1ns/10ps
`default_nettype none

module ssd_warn_timer #(
  parameter logic [ssd_pkg::WARN_CNT_W-1:0] DELAY_CYC = ssd_pkg::WARN_DELAY_CYC
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  // timer control
  ssd_warn_if.tmr   warn
);
  import ssd_pkg::*;

  // delay count and expiry flag
  typedef struct packed {
    logic [WARN_CNT_W-1:0] count;
    logic                  expired;
  } ssd_tmr_t;

  ssd_tmr_t tm_r;
  ssd_tmr_t tm_nxt;

  // counts only while the warning is continuous; any gap restarts the delay
  always_comb begin
    tm_nxt = tm_r;
    if (!warn.run) begin
      tm_nxt = '0;
    end else if (tm_r.count >= DELAY_CYC - WARN_CNT_W'(1)) begin
      tm_nxt.expired = 1'b1;
    end else begin
      tm_nxt.count = tm_r.count + WARN_CNT_W'(1);
    end
  end

  // single state register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tm_r <= '0;
    end else begin
      tm_r <= tm_nxt;
    end
  end

  assign warn.expired = tm_r.expired;

  // expiry needs the warning held through the whole count
  gap_restarts_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !warn.run |=> !tm_r.expired && tm_r.count == '0)
    else $error("warning timer not restarted after gap");

endmodule // ssd_warn_timer

`default_nettype wire

// [design/ssd_status.sv]
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - chain holds at most thirty-one sensors
// - link failure freezes safety output state unless error or output fault
// - response bit 0 shows outputs on
// - response bit 1 shows valid actuator present
// - response bit 4 shows both inputs live
// - response bit 5 shows actuator in margin
// - response bit 6 shows pending warning
// - response bit 7 shows error forced off
// - internal error switches outputs off promptly
// - error clears: cause gone, reset fall or open
// - output faults clear only at next enabling
// - warning drops diagnostic, keeps outputs on
// - warning clears itself when cause gone
// - warning lasting full delay switches outputs off
// - fault byte readable when warning or error
// - all flags are active high
// - request inbound, response and fault outbound

module ssd_status #(
  parameter logic [ssd_pkg::WARN_CNT_W-1:0] WARN_DELAY_CYC = ssd_pkg::WARN_DELAY_CYC
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  // safety input pins
  input  wire logic       guard_input_a_i,
  input  wire logic       guard_input_b_i,
  // actuator sensing
  input  wire logic       actuator_valid_i,
  input  wire logic       actuator_margin_i,
  // fault detectors
  input  wire logic       out_a_fault_i,
  input  wire logic       out_b_fault_i,
  input  wire logic       cross_short_i,
  input  wire logic       overtemp_i,
  input  wire logic       wrong_actuator_i,
  input  wire logic       internal_fault_i,
  input  wire logic       comm_fault_i,
  // request byte from the chain
  input  wire logic       req_valid_i,
  input  wire logic [7:0] req_byte_i,
  // safety outputs and diagnostic level
  output logic            safe_output_a_o,
  output logic            safe_output_b_o,
  output logic            diag_ok_o,
  // bytes toward the chain
  output logic [7:0]      resp_byte_o,
  output logic [7:0]      fault_byte_o
);
  import ssd_pkg::*;

  // whole block state
  typedef struct packed {
    logic       out_on;    // outputs driven on
    logic       err_lat;   // latched actuator or internal error
    logic       tmo_lat;   // latched warning timeout
    logic       outa_lat;  // output a fault held until next enabling
    logic       outb_lat;  // output b fault held until next enabling
    logic       rst_prev;  // last request reset bit seen
    logic       diag_ok;
    logic [7:0] resp;
    logic [7:0] fault;
  } ssd_state_t;

  ssd_state_t st_r;
  ssd_state_t st_nxt;

  logic live_a;
  logic live_b;
  logic inputs_live;
  logic warn_cause;
  logic err_cause;
  logic rst_fall;
  logic err_now;
  logic enable_ok;

  ssd_warn_if warn ();

  // pins cross into the clock domain through three stages each
  ssd_sync3 u_sync_a (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .pin_i     (guard_input_a_i),
    .level_o   (live_a)
  );

  ssd_sync3 u_sync_b (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .pin_i     (guard_input_b_i),
    .level_o   (live_b)
  );

  ssd_warn_timer #(
    .DELAY_CYC (WARN_DELAY_CYC)
  ) u_timer (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .warn      (warn)
  );

  // cause decode; cross-short and heat only warn, they do not stop at once
  assign inputs_live = live_a & live_b;
  assign warn_cause  = overtemp_i | cross_short_i;
  assign err_cause   = internal_fault_i | wrong_actuator_i;
  assign warn.run    = warn_cause;
  // reset request acts on the 1-to-0 step only, a held 0 does nothing
  assign rst_fall    = req_valid_i & ~req_byte_i[REQ_RESET] & st_r.rst_prev;

  // next state
  always_comb begin
    st_nxt = st_r;

    if (req_valid_i) begin
      st_nxt.rst_prev = req_byte_i[REQ_RESET];
    end

    // error latch; a fresh cause always wins over a clear in the same cycle
    if (err_cause) begin
      st_nxt.err_lat = 1'b1;
    end else if (rst_fall || !actuator_valid_i) begin
      st_nxt.err_lat = 1'b0;
    end

    // timeout latch behaves like any other error once set
    if (warn.expired) begin
      st_nxt.tmo_lat = 1'b1;
    end else if (!warn_cause && (rst_fall || !actuator_valid_i)) begin
      st_nxt.tmo_lat = 1'b0;
    end

    // output faults are set here, cleared below at the next enabling
    if (out_a_fault_i) begin
      st_nxt.outa_lat = 1'b1;
    end
    if (out_b_fault_i) begin
      st_nxt.outb_lat = 1'b1;
    end

    err_now   = st_nxt.err_lat | st_nxt.tmo_lat;
    enable_ok = actuator_valid_i & inputs_live & ~err_now & ~out_a_fault_i & ~out_b_fault_i;

    if (err_now || st_nxt.outa_lat || st_nxt.outb_lat) begin
      // errors override a frozen link: safety comes before holding state
      if (err_now || st_r.out_on) begin
        st_nxt.out_on = 1'b0;
      end
    end else if (comm_fault_i) begin
      st_nxt.out_on = st_r.out_on;
    end else begin
      st_nxt.out_on = enable_ok;
    end

    // a repair cannot be seen until the outputs are switched on again
    if (!st_r.out_on && !comm_fault_i && !err_now
        && actuator_valid_i && inputs_live
        && !out_a_fault_i && !out_b_fault_i
        && (st_nxt.outa_lat || st_nxt.outb_lat)) begin
      st_nxt.outa_lat = 1'b0;
      st_nxt.outb_lat = 1'b0;
      st_nxt.out_on   = 1'b1;
    end

    // response byte, all flags active high
    st_nxt.resp               = RSP_RESET_VAL;
    st_nxt.resp[RSP_OUT_ON]   = st_nxt.out_on;
    st_nxt.resp[RSP_ACTUATED] = actuator_valid_i;
    st_nxt.resp[RSP_INPUTS]   = inputs_live;
    st_nxt.resp[RSP_MARGIN]   = actuator_valid_i & actuator_margin_i;
    st_nxt.resp[RSP_WARNING]  = warn_cause;
    st_nxt.resp[RSP_ERROR]    = ~st_nxt.out_on
                              & (err_now | st_nxt.outa_lat | st_nxt.outb_lat);

    // fault detail only shown while the response flags trouble
    st_nxt.fault = FLT_RESET_VAL;
    if (st_nxt.resp[RSP_WARNING] || st_nxt.resp[RSP_ERROR]) begin
      st_nxt.fault[FLT_OUT_A]    = st_nxt.outa_lat;
      st_nxt.fault[FLT_OUT_B]    = st_nxt.outb_lat;
      st_nxt.fault[FLT_CROSS]    = cross_short_i;
      st_nxt.fault[FLT_TEMP]     = overtemp_i;
      st_nxt.fault[FLT_ACTUATOR] = wrong_actuator_i;
      st_nxt.fault[FLT_INTERNAL] = internal_fault_i;
      st_nxt.fault[FLT_COMM]     = comm_fault_i;
    end

    // diagnostic level drops during a warning so the controller can stop cleanly
    st_nxt.diag_ok = st_nxt.out_on & ~warn_cause;
  end

  // single state register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '{out_on: 1'b0, err_lat: 1'b0, tmo_lat: 1'b0, outa_lat: 1'b0,
                outb_lat: 1'b0, rst_prev: 1'b0, diag_ok: 1'b0,
                resp: RSP_RESET_VAL, fault: FLT_RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  // both channels switch together from one bit
  assign safe_output_a_o = st_r.out_on;
  assign safe_output_b_o = st_r.out_on;
  assign diag_ok_o       = st_r.diag_ok;
  assign resp_byte_o     = st_r.resp;
  assign fault_byte_o    = st_r.fault;

  // steps of the error reset and of warning recovery
  sequence err_latched_s;
    st_r.err_lat && !err_cause;
  endsequence

  sequence reset_fall_s;
    req_valid_i && st_r.rst_prev && !req_byte_i[REQ_RESET];
  endsequence

  sequence warn_gone_s;
    resp_byte_o[RSP_WARNING] ##0 !warn_cause;
  endsequence

  sequence guard_open_s;
    !actuator_valid_i;
  endsequence

  out_flag_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    resp_byte_o[RSP_OUT_ON] == safe_output_a_o)
    else $error("response bit 0 differs from safety output");

  actuated_flag_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> resp_byte_o[RSP_ACTUATED] == $past(actuator_valid_i))
    else $error("response bit 1 not tracking actuator");

  inputs_flag_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    resp_byte_o[RSP_INPUTS] |-> $past(live_a) && $past(live_b))
    else $error("response bit 4 set without both inputs live");

  internal_off_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    internal_fault_i |=> !safe_output_a_o && !safe_output_b_o && resp_byte_o[RSP_ERROR])
    else $error("outputs not off after internal fault");

  comm_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    comm_fault_i && !err_cause && !warn.expired && !out_a_fault_i && !out_b_fault_i
    && !st_r.err_lat && !st_r.tmo_lat && !st_r.outa_lat && !st_r.outb_lat
    |=> safe_output_a_o == $past(safe_output_a_o))
    else $error("outputs changed during link failure");

  err_reset_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    err_latched_s ##0 reset_fall_s |=> !st_r.err_lat)
    else $error("error not cleared by reset request");

  err_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    st_r.err_lat && actuator_valid_i && !rst_fall |=> st_r.err_lat)
    else $error("error cleared without reset or opening");

  outfault_clear_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $fell(st_r.outa_lat) |-> safe_output_a_o)
    else $error("output fault cleared without enabling");

  warn_diag_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    resp_byte_o[RSP_WARNING] |-> !diag_ok_o)
    else $error("diagnostic level high during warning");

  warn_auto_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    warn_gone_s |=> !resp_byte_o[RSP_WARNING])
    else $error("warning flag did not clear by itself");

  warn_timeout_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    warn.expired |=> !safe_output_a_o ##1 !safe_output_a_o)
    else $error("outputs still on after warning delay");

  fault_gate_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !resp_byte_o[RSP_WARNING] && !resp_byte_o[RSP_ERROR] |-> fault_byte_o == 8'h00)
    else $error("fault byte shown without warning or error");

  outputs_equal_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    safe_output_a_o == safe_output_b_o)
    else $error("safety outputs differ");

  margin_flag_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    resp_byte_o[RSP_MARGIN] |-> resp_byte_o[RSP_ACTUATED])
    else $error("margin flag without actuator");

  warn_flag_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> resp_byte_o[RSP_WARNING] == $past(warn_cause))
    else $error("warning flag not tracking its cause");

  error_flag_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    resp_byte_o[RSP_ERROR] |-> !safe_output_a_o)
    else $error("error flag with outputs on");

  wrong_act_off_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wrong_actuator_i |=> !safe_output_a_o && resp_byte_o[RSP_ERROR])
    else $error("outputs not off after wrong actuator");

  outfault_off_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    out_a_fault_i || out_b_fault_i |=> !safe_output_a_o)
    else $error("outputs on with output fault");

  outfault_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    st_r.outa_lat && !actuator_valid_i |=> st_r.outa_lat)
    else $error("output fault cleared while guard open");

  warn_keeps_on_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    st_r.out_on && warn_cause && !warn.expired && !err_cause && !out_a_fault_i && !out_b_fault_i && inputs_live
    && actuator_valid_i && !st_r.err_lat && !st_r.tmo_lat && !st_r.outa_lat && !st_r.outb_lat |=> safe_output_a_o)
    else $error("outputs dropped during warning");

  fault_shown_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    resp_byte_o[RSP_WARNING] |-> fault_byte_o[FLT_CROSS] || fault_byte_o[FLT_TEMP])
    else $error("warning without fault detail");

  internal_map_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    resp_byte_o[RSP_ERROR] |-> fault_byte_o[FLT_INTERNAL] == $past(internal_fault_i))
    else $error("internal fault bit wrong");

  timeout_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    st_r.tmo_lat && warn_cause |=> st_r.tmo_lat)
    else $error("timeout cleared while warning present");

  timeout_latch_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    warn.expired |=> st_r.tmo_lat)
    else $error("timeout not latched");

  diag_on_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    diag_ok_o |-> safe_output_a_o)
    else $error("diagnostic level high with outputs off");

  err_open_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    err_latched_s ##0 guard_open_s |=> !st_r.err_lat)
    else $error("error not cleared by opening");

  comm_bit_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    resp_byte_o[RSP_WARNING] || resp_byte_o[RSP_ERROR] |-> fault_byte_o[FLT_COMM] == $past(comm_fault_i))
    else $error("link fault bit wrong");

endmodule // ssd_status

`default_nettype wire

// [dv/ssd_gw_model.sv]
`timescale 1ns/10ps
`default_nettype none

// gateway end of the diagnostic chain: mirrors status, issues request bytes
module ssd_gw_model (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  // bytes from the sensor
  input  wire logic [7:0] resp_byte_i,
  input  wire logic [7:0] fault_byte_i,
  // request toward the sensor
  output logic            req_valid_o,
  output logic [7:0]      req_byte_o,
  // controller input byte copies
  output logic [7:0]      in_rsp_o,
  output logic [7:0]      in_flt_o
);
  // idle line shows a pattern, not a stale byte
  initial begin
    req_valid_o = 1'b0;
    req_byte_o  = 8'h5a;
  end

  // copies refreshed every cycle, never on demand only
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_rsp_o <= 8'h00;
      in_flt_o <= 8'h00;
    end else begin
      in_rsp_o <= resp_byte_i;
      in_flt_o <= fault_byte_i;
    end
  end

  // one request byte, valid for exactly one edge
  task automatic send(input logic [7:0] b);
    @(posedge sys_clk_i);
    req_valid_o <= 1'b1;
    req_byte_o  <= b;
    @(posedge sys_clk_i);
    req_valid_o <= 1'b0;
    req_byte_o  <= ~b; // inverse so a late sample cannot pass
  endtask
endmodule // ssd_gw_model

`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ssd_pkg::*;
  // short warning delay keeps the run brief
  localparam logic [WARN_CNT_W-1:0] DLY = 38'h14;
  logic       sys_clk, resetn, ga, gb, act, marg, fa, fb, xs, ot, wa, intf, cf;
  wire logic  rv, oa, ob, dg;
  wire logic [7:0] rb, rsp, flt;
  wire logic [7:0] gw_rsp, gw_flt;
  int         n_mismatch, n_compared;

  ssd_status #(.WARN_DELAY_CYC(DLY)) dut (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .guard_input_a_i(ga), .guard_input_b_i(gb),
    .actuator_valid_i(act), .actuator_margin_i(marg), .out_a_fault_i(fa), .out_b_fault_i(fb),
    .cross_short_i(xs), .overtemp_i(ot), .wrong_actuator_i(wa), .internal_fault_i(intf),
    .comm_fault_i(cf), .req_valid_i(rv), .req_byte_i(rb), .safe_output_a_o(oa),
    .safe_output_b_o(ob), .diag_ok_o(dg), .resp_byte_o(rsp), .fault_byte_o(flt));

  ssd_gw_model gw (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .resp_byte_i(rsp), .fault_byte_i(flt),
    .req_valid_o(rv), .req_byte_o(rb), .in_rsp_o(gw_rsp), .in_flt_o(gw_flt));

  // free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  // whole status picture in one call
  task automatic st(input logic [7:0] r, input logic [7:0] f, input logic o, input logic d);
    chk_byte("response byte", r, rsp);
    chk_byte("fault byte", f, flt);
    chk_bit("output a", o, oa);
    chk_bit("output b", o, ob);
    chk_bit("diag level", d, dg);
  endtask

  task automatic go(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // sample away from the edge so updates have landed
  task automatic look(input int n);
    go(n);
    #1;
  endtask

  task complete_run;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {ga, gb, act, marg, fa, fb, xs, ot, wa, intf, cf} = '0;
    resetn = 1'b0;
    look(3);
    st(8'h00, 8'h00, 1'b0, 1'b0);
    go(5);
    resetn <= 1'b1;
    go(1);
    ga <= 1'b1;
    gb <= 1'b1;
    look(8);
    st(8'h10, 8'h00, 1'b0, 1'b0);
    go(1);
    act <= 1'b1;
    look(2);
    st(8'h13, 8'h00, 1'b1, 1'b1);
    chk_byte("gateway copy", 8'h13, gw_rsp);
    go(1);
    marg <= 1'b1;
    look(2);
    st(8'h33, 8'h00, 1'b1, 1'b1);
    go(1);
    marg <= 1'b0;
    // either dead channel clears the flag and drops the outputs
    for (int i = 0; i < 2; i++) begin
      go(1);
      if (i == 0) ga <= 1'b0;
      else gb <= 1'b0;
      look(8);
      chk_bit("inputs live", 1'b0, rsp[4]);
      st(8'h02, 8'h00, 1'b0, 1'b0);
      go(1);
      ga <= 1'b1;
      gb <= 1'b1;
      look(8);
    end
    // both warning causes: outputs stay on, diag drops, self-clearing
    for (int i = 0; i < 2; i++) begin
      go(1);
      if (i == 0) ot <= 1'b1;
      else xs <= 1'b1;
      look(2);
      st(8'h53, (i == 0) ? 8'h08 : 8'h04, 1'b1, 1'b0);
      chk_byte("gateway fault copy", (i == 0) ? 8'h08 : 8'h04, gw_flt);
      go(1);
      ot <= 1'b0;
      xs <= 1'b0;
      look(2);
      st(8'h13, 8'h00, 1'b1, 1'b1);
    end
    // both error causes: one cleared by request, one by opening
    for (int i = 0; i < 2; i++) begin
      go(1);
      if (i == 0) intf <= 1'b1;
      else wa <= 1'b1;
      look(2);
      st(8'h92, (i == 0) ? 8'h20 : 8'h10, 1'b0, 1'b0);
      gw.send(8'h80);
      gw.send(8'h00);
      look(2);
      chk_bit("reset with cause", 1'b1, rsp[7]);
      go(1);
      intf <= 1'b0;
      wa   <= 1'b0;
      look(3);
      chk_bit("error latched", 1'b1, rsp[7]);
      if (i == 0) begin
        gw.send(8'h80);
        gw.send(8'h00);
      end else begin
        go(1);
        act <= 1'b0;
        look(2);
        chk_byte("opened", 8'h10, rsp);
        go(1);
        act <= 1'b1;
      end
      look(2);
      st(8'h13, 8'h00, 1'b1, 1'b1);
    end
    // either output fault persists until the next enabling
    for (int i = 0; i < 2; i++) begin
      go(1);
      if (i == 0) fa <= 1'b1;
      else fb <= 1'b1;
      look(2);
      chk_bit("output a", 1'b0, oa);
      chk_bit("fault out", 1'b1, flt[i]);
      st(8'h92, (i == 0) ? 8'h01 : 8'h02, 1'b0, 1'b0);
      go(1);
      act <= 1'b0;
      fa  <= 1'b0;
      fb  <= 1'b0;
      look(3);
      chk_bit("output a", 1'b0, oa);
      st(8'h90, (i == 0) ? 8'h01 : 8'h02, 1'b0, 1'b0);
      go(1);
      act <= 1'b1;
      look(2);
      st(8'h13, 8'h00, 1'b1, 1'b1);
    end
    // lost link holds the outputs even when the actuator leaves
    go(1);
    cf  <= 1'b1;
    act <= 1'b0;
    look(4);
    chk_bit("output hold", 1'b1, oa);
    st(8'h11, 8'h00, 1'b1, 1'b1);
    go(1);
    cf  <= 1'b0;
    act <= 1'b1;
    // warning left standing past the delay
    go(1);
    ot <= 1'b1;
    look(10);
    chk_bit("output early", 1'b1, oa);
    look(16);
    chk_bit("output late", 1'b0, oa);
    chk_bit("error flag", 1'b1, rsp[7]);
    go(1);
    ot <= 1'b0;
    gw.send(8'h80);
    gw.send(8'h00);
    look(2);
    st(8'h13, 8'h00, 1'b1, 1'b1);
    complete_run;
  end

  // hang guard, far beyond the roughly 170 cycles needed
  initial begin
    go(3000);
    n_mismatch++;
    complete_run;
  end
endmodule // tb

`default_nettype wire
